// ==== common/pmi_pkg.sv ====
// Shared constants and state types of the phone MCU interrupt unit
package pmi_pkg;

    // ****************************************************************
    // Register map (index per register, byte address is four times it)
    // ****************************************************************
    localparam int               NSRC        = 5;
    localparam int               AW          = 8;
    localparam logic [7:0]       IDX_CTRL_A  = 8'h0b;
    localparam logic [7:0]       IDX_CTRL_B  = 8'h1e;
    localparam logic [7:0]       IDX_STS     = 8'h20;
    localparam logic [7:0]       IDX_MSK     = 8'h21;
    localparam logic [AW-1:0]    ADDR_CTRL_A = {IDX_CTRL_A[5:0], 2'b00};
    localparam logic [AW-1:0]    ADDR_CTRL_B = {IDX_CTRL_B[5:0], 2'b00};
    localparam logic [AW-1:0]    ADDR_STS    = {IDX_STS[5:0], 2'b00};
    localparam logic [AW-1:0]    ADDR_MSK    = {IDX_MSK[5:0], 2'b00};

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int A_GIE    = 0;
    localparam int A_EXT_EN = 1;
    localparam int A_T0_EN  = 2;
    localparam int A_T1_EN  = 3;
    localparam int A_EXT_F  = 4;
    localparam int A_T0_F   = 5;
    localparam int A_T1_F   = 6;
    localparam int B_RSV0   = 0;
    localparam int B_CLK_EN = 1;
    localparam int B_DIA_EN = 2;
    localparam int B_RSV4   = 4;
    localparam int B_CLK_F  = 5;
    localparam int B_DIA_F  = 6;
    localparam int SRC_EXT  = 0;
    localparam int SRC_T0   = 1;
    localparam int SRC_T1   = 2;
    localparam int SRC_CLK  = 3;
    localparam int SRC_DIA  = 4;

    // ****************************************************************
    // Vectors, responses and reset values
    // ****************************************************************
    localparam logic [7:0]      VEC_EXT     = 8'h04;
    localparam logic [7:0]      VEC_T0      = 8'h08;
    localparam logic [7:0]      VEC_T1      = 8'h0c;
    localparam logic [7:0]      VEC_CLK     = 8'h14;
    localparam logic [7:0]      VEC_DIA     = 8'h18;
    localparam logic [1:0]      RESP_OKAY   = 2'h0;
    localparam logic [1:0]      RESP_SLVERR = 2'h2;
    localparam logic            RST_GIE     = 1'b0;
    localparam logic [NSRC-1:0] RST_EN      = 5'h00;
    localparam logic [NSRC-1:0] RST_FLAG    = 5'h00;
    localparam logic [NSRC-1:0] RST_MSK     = 5'h00;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } pmi_sync_s;

    typedef struct packed {
        logic            gie;
        logic [NSRC-1:0] src_en;
        logic [NSRC-1:0] flag;
        logic [1:0]      rsv;
        logic [NSRC-1:0] sts;
        logic [NSRC-1:0] msk;
        logic            call_valid;
        logic [7:0]      call_vector;
        logic            aw_have;
        logic [AW-1:0]   aw_addr;
        logic            w_have;
        logic [7:0]      w_data;
        logic            w_lane0;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [7:0]      rdata;
        logic [1:0]      rresp;
    } pmi_core_s;

endpackage : pmi_pkg

// ==== common/pmi_req_if.sv ====
// Pending requests and the selected winner between core and selector
`timescale 1ns/1ps
`default_nettype none
interface pmi_req_if;
    import pmi_pkg::*;
    logic [NSRC-1:0] pending;
    logic            hit;
    logic [2:0]      idx;
    logic [7:0]      vector;
    modport src (output pending, input hit, input idx, input vector);
    modport sel (input pending, output hit, output idx, output vector);
endinterface : pmi_req_if
`default_nettype wire

// ==== design/pmi_pin_edge.sv ====
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module pmi_pin_edge
    import pmi_pkg::*;
#(
    parameter logic RST_LVL = 1'b1
)
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    pmi_sync_s st;
    pmi_sync_s next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= {RST_LVL, RST_LVL, RST_LVL};
        else
            st <= next_st;
    end

    // Registered samples compared, so each transition gives one pulse
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
endmodule : pmi_pin_edge
`default_nettype wire

// ==== design/pmi_prio_sel.sv ====
// Fixed-priority selector from pending requests to vector
`timescale 1ns/1ps
`default_nettype none
module pmi_prio_sel
    import pmi_pkg::*;
(
    pmi_req_if.sel req
);
    always_comb
    begin
        req.hit    = 1'b0;
        req.idx    = 3'h0;
        req.vector = 8'h00;
        // Scan downward so the lowest index, the highest priority, wins
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (req.pending[i])
            begin
                req.hit = 1'b1;
                req.idx = 3'(i);
            end
        end
        if (req.hit)
        begin
            case (req.idx)
                3'h0:    req.vector = VEC_EXT;
                3'h1:    req.vector = VEC_T0;
                3'h2:    req.vector = VEC_T1;
                3'h3:    req.vector = VEC_CLK;
                3'h4:    req.vector = VEC_DIA;
                default: req.vector = 8'h00;
            endcase
        end
    end
endmodule : pmi_prio_sel
`default_nettype wire

// ==== design/pmi_irq_unit.sv ====
// Vectored interrupt unit with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pmi_irq_unit
    import pmi_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          ext_irq_n,
    input  wire logic          hook_sense_n,
    input  wire logic          hold_detect_n,
    input  wire logic          handsfree_in,
    input  wire logic          timer0_ovf,
    input  wire logic          timer1_ovf,
    input  wire logic          clock_tick,
    input  wire logic          on_hook,
    input  wire logic          hold_line,
    input  wire logic          idle_mode,
    input  wire logic          phase_two_clock,
    input  wire logic          stack_full,
    input  wire logic          return_from_irq,
    input  wire logic          return_plain,
    output logic               call_valid,
    output logic [7:0]         call_vector,
    output logic               push_pc,
    output logic               wake_req,
    output logic               irq
);

    // ****************************************************************
    // Pin edges
    // ****************************************************************
    logic ext_fall;
    logic hook_rise;
    logic hook_fall;
    logic hold_fall;
    logic hf_rise;

    pmi_pin_edge #(.RST_LVL(1'b1)) u_ext (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (ext_irq_n),
        .rise    (),
        .fall    (ext_fall)
    );
    pmi_pin_edge #(.RST_LVL(1'b1)) u_hook (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (hook_sense_n),
        .rise    (hook_rise),
        .fall    (hook_fall)
    );
    pmi_pin_edge #(.RST_LVL(1'b1)) u_hold (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (hold_detect_n),
        .rise    (),
        .fall    (hold_fall)
    );
    pmi_pin_edge #(.RST_LVL(1'b0)) u_hf (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (handsfree_in),
        .rise    (hf_rise),
        .fall    ()
    );

    // ****************************************************************
    // Request sources and selection
    // ****************************************************************
    pmi_core_s       st;
    pmi_core_s       next_st;
    pmi_req_if       req ();
    logic [NSRC-1:0] hw_set;
    logic [NSRC-1:0] en_eff;
    logic            dial_evt;
    logic            take_now;
    logic            ar_hs;
    logic            wr_go;
    logic            wr_a;
    logic            wr_b;

    pmi_prio_sel u_sel (
        .req (req)
    );

    // A held line in the on-hook state would otherwise fire spuriously
    assign dial_evt = hook_rise | hook_fall | hf_rise
                    | (hold_fall & ~(on_hook & hold_line));

    always_comb
    begin
        hw_set          = '0;
        hw_set[SRC_EXT] = ext_fall;
        hw_set[SRC_T0]  = timer0_ovf;
        hw_set[SRC_T1]  = timer1_ovf;
        hw_set[SRC_CLK] = clock_tick;
        hw_set[SRC_DIA] = dial_evt;
    end

    always_comb
    begin
        en_eff          = st.src_en;
        en_eff[SRC_DIA] = st.src_en[SRC_DIA] & ~idle_mode;
    end

    // Enables gate service and wake_req only; the flag itself is never touched
    assign req.pending = st.flag & en_eff;
    assign take_now    = phase_two_clock & st.gie & ~stack_full & req.hit;
    assign wake_req    = |req.pending;

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    assign ar_hs = s_axi_arvalid & ~st.rvalid;
    assign wr_go = st.aw_have & st.w_have & ~st.bvalid;
    assign wr_a  = wr_go & st.w_lane0 & (st.aw_addr == ADDR_CTRL_A);
    assign wr_b  = wr_go & st.w_lane0 & (st.aw_addr == ADDR_CTRL_B);

    always_comb
    begin
        next_st            = st;
        next_st.call_valid = 1'b0;

        // Write channel capture, address and data in either order
        if (s_axi_awvalid && !st.aw_have)
        begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_have)
        begin
            next_st.w_have  = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (wr_go)
        begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            case (st.aw_addr)
                ADDR_CTRL_A,
                ADDR_CTRL_B,
                ADDR_STS,
                ADDR_MSK: next_st.bresp = RESP_OKAY;
                default:  next_st.bresp = RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;

        // ************************************************************
        // Software writes
        // ************************************************************
        if (wr_a)
        begin
            next_st.gie             = st.w_data[A_GIE];
            next_st.src_en[SRC_EXT] = st.w_data[A_EXT_EN];
            next_st.src_en[SRC_T0]  = st.w_data[A_T0_EN];
            next_st.src_en[SRC_T1]  = st.w_data[A_T1_EN];
            next_st.flag[SRC_EXT]   = st.w_data[A_EXT_F];
            next_st.flag[SRC_T0]    = st.w_data[A_T0_F];
            next_st.flag[SRC_T1]    = st.w_data[A_T1_F];
        end
        if (wr_b)
        begin
            next_st.rsv[0]          = st.w_data[B_RSV0];
            next_st.rsv[1]          = st.w_data[B_RSV4];
            next_st.src_en[SRC_CLK] = st.w_data[B_CLK_EN];
            next_st.src_en[SRC_DIA] = st.w_data[B_DIA_EN];
            next_st.flag[SRC_CLK]   = st.w_data[B_CLK_F];
            next_st.flag[SRC_DIA]   = st.w_data[B_DIA_F];
        end
        if (wr_go && st.w_lane0 && st.aw_addr == ADDR_MSK)
            next_st.msk = st.w_data[NSRC-1:0];

        // ************************************************************
        // Return and service
        // ************************************************************
        if (return_from_irq)
            next_st.gie = 1'b1;
        if (take_now)
        begin
            next_st.gie              = 1'b0;
            next_st.flag[req.idx]    = 1'b0;
            next_st.call_valid       = 1'b1;
            next_st.call_vector      = req.vector;
        end
        // A hardware event in the clearing cycle is kept
        next_st.flag = next_st.flag | hw_set;

        // ************************************************************
        // Reads, with clear-on-read of the event status
        // ************************************************************
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (ar_hs)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = 8'h00;
            case (s_axi_araddr)
                ADDR_CTRL_A:
                    next_st.rdata = {1'b0, st.flag[SRC_T1:SRC_EXT],
                                     st.src_en[SRC_T1:SRC_EXT], st.gie};
                ADDR_CTRL_B:
                    next_st.rdata = {1'b0, st.flag[SRC_DIA:SRC_CLK], st.rsv[1],
                                     1'b0, st.src_en[SRC_DIA:SRC_CLK], st.rsv[0]};
                ADDR_STS:
                begin
                    next_st.rdata = {3'h0, st.sts};
                    next_st.sts   = '0;
                end
                ADDR_MSK:
                    next_st.rdata = {3'h0, st.msk};
                default:
                    next_st.rresp = RESP_SLVERR;
            endcase
        end
        next_st.sts = next_st.sts | hw_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st        <= '0;
            st.gie    <= RST_GIE;
            st.src_en <= RST_EN;
            st.flag   <= RST_FLAG;
            st.msk    <= RST_MSK;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = ~st.aw_have;
    assign s_axi_wready  = ~st.w_have;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = ~st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = {24'h000000, st.rdata};
    // Only the program counter goes to the stack; status is software's job
    assign call_valid    = st.call_valid;
    assign push_pc       = st.call_valid;
    assign call_vector   = st.call_vector;
    assign irq           = |(st.sts & st.msk);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_TAKE_CLEARS_GIE: assert property (
        st.call_valid |-> !st.gie
    ) else $error("Global enable still set after a take");

    AST_STACK_FULL_BLOCKS: assert property (
        stack_full |=> !st.call_valid
    ) else $error("Interrupt taken while the stack was full");

    AST_TAKE_ON_PHASE_TWO: assert property (
        st.call_valid |-> $past(phase_two_clock) && $past(st.gie)
    ) else $error("Interrupt taken outside a phase-two pulse");

    AST_EXT_WINS_VECTOR: assert property (
        st.call_valid && $past(st.flag[SRC_EXT] & st.src_en[SRC_EXT])
        |-> st.call_vector == VEC_EXT
    ) else $error("External request did not win priority");

    AST_EXT_EDGE_SETS: assert property (
        ext_fall |=> st.flag[SRC_EXT]
    ) else $error("External edge did not set its flag");

    AST_RETURN_FROM_IRQ_SETS_GIE: assert property (
        return_from_irq && !take_now |=> st.gie
    ) else $error("Return from interrupt left global enable clear");

    AST_RET_KEEPS_GIE: assert property (
        return_plain && !return_from_irq && !take_now && !wr_a
        |=> st.gie == $past(st.gie)
    ) else $error("Plain return changed global enable");

    AST_FLAG_STICKY: assert property (
        st.flag[SRC_T0] && !take_now && !wr_a |=> st.flag[SRC_T0]
    ) else $error("Timer 0 flag dropped without service or clear");

    AST_IDLE_NO_DIALER: assert property (
        idle_mode && take_now |-> req.idx != 3'(SRC_DIA)
    ) else $error("Dialer interrupt taken in Idle mode");

    AST_TIMER1_VECTOR: assert property (
        take_now && req.pending == 5'h04 |=> st.call_vector == VEC_T1 ##1 !st.call_valid
    ) else $error("Timer 1 service used a wrong vector");

endmodule : pmi_irq_unit
`default_nettype wire

// ==== test/pmi_core_model.sv ====
// Core-side model: phase-two pulse train and a bounded return stack
`timescale 1ns/1ps
`default_nettype none
module pmi_core_model
#(
    parameter int DEPTH = 2
)
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic push_pc,
    input  wire logic pop,
    output logic      phase_two_clock,
    output logic      stack_full
);
    int unsigned ph;
    int unsigned sp;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph <= 0;
            sp <= 0;
        end
        else
        begin
            ph <= (ph + 1) % 4;
            // Only the return address is stacked, one entry per call
            if (push_pc && !pop)
                sp <= sp + 1;
            else if (pop && !push_pc && sp > 0)
                sp <= sp - 1;
        end
    end
    // Service slots come once per instruction cycle, never back to back
    assign phase_two_clock = (ph == 3);
    assign stack_full      = (sp >= DEPTH);
endmodule : pmi_core_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmi_pkg::*;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [AW-1:0] awaddr = '0;
    logic [AW-1:0] araddr = '0;
    logic [31:0]   wdata = '0;
    logic          awvalid = 1'b0;
    logic          wvalid = 1'b0;
    logic          bready = 1'b0;
    logic          arvalid = 1'b0;
    logic          rready = 1'b0;
    logic [3:0]    pin = 4'h7;
    logic [3:0]    wstrb = 4'hf;
    logic [4:0]    ev = 5'h00;
    logic [2:0]    lvl = 3'h0;
    logic [31:0]   rdata;
    logic [1:0]    bresp, rresp;
    logic          awready, wready, bvalid, arready, rvalid, p2, sfull;
    logic          call_valid, push_pc, wake_req, irq;
    logic [7:0]    call_vector;
    int            miscompares = 0;
    int            n_tests = 0;
    int            cyc = 0;

    always #2.5 aclk = ~aclk;

    pmi_irq_unit dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_irq_n(pin[0]), .hook_sense_n(pin[1]), .hold_detect_n(pin[2]),
        .handsfree_in(pin[3]), .timer0_ovf(ev[0]), .timer1_ovf(ev[1]), .clock_tick(ev[2]),
        .on_hook(lvl[0]), .hold_line(lvl[1]), .idle_mode(lvl[2]), .phase_two_clock(p2),
        .stack_full(sfull), .return_from_irq(ev[3]), .return_plain(ev[4]),
        .call_valid(call_valid), .call_vector(call_vector), .push_pc(push_pc),
        .wake_req(wake_req), .irq(irq));

    pmi_core_model #(.DEPTH(2)) core_u (
        .aclk(aclk), .aresetn(aresetn), .push_pc(push_pc), .pop(ev[3] | ev[4]),
        .phase_two_clock(p2), .stack_full(sfull));

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Handshakes are judged on the level held into the coming rising edge
    task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
        while (!tb);
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid & rready;
            d = rdata[7:0];
            r = rresp;
            @(posedge aclk);
            if (ta)
                arvalid <= 1'b0;
        end
        while (!tr);
        rready <= 1'b0;
    endtask : axr

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk("bresp", {6'h00, r}, {6'h00, RESP_OKAY});
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(nm, d, e);
        chk(nm, {6'h00, r}, {6'h00, RESP_OKAY});
    endtask : rdc

    // Expects one call with vector e, or none at all when e is zero
    task automatic ecall(input logic [7:0] e, input string nm);
        logic [1:0] g;
        logic [7:0] v;
        int         n;
        g = 2'b00;
        v = 8'h00;
        n = 24;
        while (n > 0 && g == 2'b00)
        begin
            @(negedge aclk);
            n--;
            if (call_valid === 1'b1)
            begin
                g = {call_valid, push_pc};
                v = call_vector;
            end
        end
        chk(nm, {6'h00, g}, (e == 8'h00) ? 8'h00 : 8'h03);
        chk(nm, v, e);
    endtask : ecall

    task pulse(input int i);
        @(posedge aclk);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev[i] <= 1'b0;
    endtask : pulse

    task setp(input int i, input logic v);
        @(posedge aclk);
        pin[i] <= v;
        repeat (4) @(posedge aclk);
    endtask : setp

    task t_regs();
        logic [7:0] d;
        logic [1:0] r;
        rdc(ADDR_CTRL_A, 8'h00, "ctrl_a reset");
        rdc(ADDR_CTRL_B, 8'h00, "ctrl_b reset");
        rdc(ADDR_MSK, 8'h00, "mask reset");
        wr(ADDR_CTRL_A, 8'hfe);
        rdc(ADDR_CTRL_A, 8'h7e, "ctrl_a fields");
        wr(ADDR_CTRL_B, 8'hff);
        rdc(ADDR_CTRL_B, 8'h77, "ctrl_b fields");
        ecall(8'h00, "global off");
        chk("wake", {7'h00, wake_req}, 8'h01);
        axr(8'h40, d, r);
        chk("unmapped read", {6'h00, r}, {6'h00, RESP_SLVERR});
        axw(8'h44, 8'h01, r);
        chk("unmapped write", {6'h00, r}, {6'h00, RESP_SLVERR});
    endtask : t_regs

    task automatic t_prio();
        logic [7:0] vec [5] = '{VEC_EXT, VEC_T0, VEC_T1, VEC_CLK, VEC_DIA};
        logic [7:0] ea [5] = '{8'h6e, 8'h4e, 8'h0e, 8'h0e, 8'h0e};
        logic [7:0] eb [5] = '{8'h77, 8'h77, 8'h77, 8'h57, 8'h17};
        for (int i = 0; i < 5; i++)
        begin
            pulse(3);
            ecall(vec[i], "vector");
            rdc(ADDR_CTRL_A, ea[i], "ctrl_a taken");
            rdc(ADDR_CTRL_B, eb[i], "ctrl_b taken");
        end
        pulse(4);
        rdc(ADDR_CTRL_A, 8'h0e, "plain return");
    endtask : t_prio

    task automatic t_src();
        int         pi [7] = '{3, 3, 1, 1, 2, 2, 2};
        logic       pv [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [7:0] eb [7] = '{8'h57, 8'h17, 8'h57, 8'h57, 8'h57, 8'h17, 8'h17};
        pulse(0);
        rdc(ADDR_CTRL_A, 8'h2e, "timer0 flag");
        pulse(1);
        setp(0, 1'b0);
        setp(0, 1'b1);
        rdc(ADDR_CTRL_A, 8'h7e, "ext timer1 flags");
        pulse(2);
        rdc(ADDR_CTRL_B, 8'h37, "tick flag");
        wr(ADDR_CTRL_B, 8'h17);
        for (int i = 0; i < 7; i++)
        begin
            lvl[1:0] <= (i > 4) ? 2'b11 : 2'b00;
            setp(pi[i], pv[i]);
            rdc(ADDR_CTRL_B, eb[i], "dialer flag");
            wr(ADDR_CTRL_B, 8'h17);
        end
        lvl[1:0] <= 2'b00;
        wr(ADDR_CTRL_A, 8'h0e);
    endtask : t_src

    // Two nested calls fill the stack; the third waits for a pop
    task t_stack();
        for (int i = 0; i < 3; i++)
            fork
                wr(ADDR_CTRL_A, 8'h1f);
                ecall((i < 2) ? VEC_EXT : 8'h00, "nesting");
            join
        pulse(4);
        ecall(VEC_EXT, "after pop");
        pulse(4);
        pulse(4);
    endtask : t_stack

    task t_idle();
        lvl[2] <= 1'b1;
        wr(ADDR_CTRL_B, 8'h57);
        @(negedge aclk);
        chk("wake idle", {7'h00, wake_req}, 8'h00);
        pulse(3);
        ecall(8'h00, "idle call");
        @(posedge aclk);
        lvl[2] <= 1'b0;
        ecall(VEC_DIA, "idle left");
    endtask : t_idle

    task t_irq();
        logic [7:0] d;
        logic [1:0] r;
        wr(ADDR_MSK, 8'h02);
        // A write with lane 0 off must leave the register alone
        wstrb <= 4'h0;
        wr(ADDR_MSK, 8'h1f);
        wstrb <= 4'hf;
        rdc(ADDR_MSK, 8'h02, "mask strobe off");
        axr(ADDR_STS, d, r);
        pulse(1);
        @(negedge aclk);
        chk("irq masked", {7'h00, irq}, 8'h00);
        pulse(0);
        @(negedge aclk);
        chk("irq raised", {7'h00, irq}, 8'h01);
        rdc(ADDR_STS, 8'h06, "status");
        @(negedge aclk);
        chk("irq cleared", {7'h00, irq}, 8'h00);
    endtask : t_irq

    task close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_prio();
        t_src();
        t_stack();
        t_idle();
        t_irq();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
